// ---- verilog/ura_top.sv ----
/*
 * usb device resume detection, wake sequencing and attach status with apb registers.
 * assumes synchronous line-state and bus-supply inputs and a single 40 MHz clock.
 */
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ura_top
  import ura_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int SHIFT_CYCLES = HS_SHIFT_CYC
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [1:0] LINE_LEVEL_I,
  input wire logic BUS_SUPPLY_I,
  output logic IRQ_OUT_N_O,
  output logic CLK_RUN_O,
  output logic XCVR_SPEED_SEL_O,
  output logic TERMINATION_SEL_O,
  output logic [1:0] OPERATING_MODE_O,
  output logic BUS_ACTIVE_O,
  output logic BUS_DETECT_DISABLE_O
);

  // ****************************************************
  // elaboration checks
  // ****************************************************
  initial begin
    // the shift counter is 16 bits wide, so longer shift delays cannot be served
    if (WAKE_CYCLES < 1 || SHIFT_CYCLES < 1 || SHIFT_CYCLES > 65536) begin
      $error("ura_top: cycle counts out of range");
    end
  end

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [1:0] rst_sync; // reset release pipe
    logic go_awake; // wake command pending
    logic [31:0] wake_cnt; // oscillator and pll start count
    logic [1:0] power_state;
    logic restore_bus;
    logic bus_active;
    logic bus_detect_disable;
    logic suspended; // firmware declares suspend
    logic saved_speed; // 1 = was high speed
    logic non_idle_seen;
    logic restore_done;
    logic [3:0] irq_en; // top, group, done, non-idle
    logic xcvr_speed_sel;
    logic termination_sel;
    logic [1:0] operating_mode;
    ura_rst_t rst_st;
    logic [15:0] shift_cnt; // hs shift delay after k ends
    logic [31:0] rdata;
  } ura_state_t;

  ura_state_t s_q, s_d;
  logic rst_n; // synchronised reset
  logic wr, rd, hit;
  logic [31:0] w;

  assign rst_n = s_q.rst_sync[1];
  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd = PSEL_I & ~PENABLE_I & ~PWRITE_I; // read data latched in setup
  assign w = PWDATA_I;
  assign hit = (PADDR_I == URA_CTRL_ADDR) | (PADDR_I == URA_STAT_ADDR) |
               (PADDR_I == URA_XCVR_ADDR) | (PADDR_I == URA_IEN_ADDR);

  // gated interrupt combine, held while any enabled flag stands
  function automatic logic irq_any(input logic [3:0] en, input logic ni, input logic dn);
    irq_any = en[IEN_TOP] & en[IEN_GROUP] & ((en[IEN_NON_IDLE] & ni) | (en[IEN_DONE] & dn));
  endfunction

  // ****************************************************
  // next-state logic
  // ****************************************************
  always_comb begin
    logic asleep;
    logic line_k;
    asleep = 1'b0;
    line_k = 1'b0;
    s_d = s_q;
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
    asleep = (s_q.power_state == PWR_SLEEP);
    line_k = (LINE_LEVEL_I == LINE_K);
    // k while sleeping is a resume request; j is idle
    if (asleep && line_k) begin
      s_d.non_idle_seen = 1'b1;
    end
    // wake: count startup, then report active and run clock
    if (s_q.go_awake) begin
      if (s_q.wake_cnt >= 32'(WAKE_CYCLES - 1)) begin
        s_d.power_state = PWR_ACTIVE;
        s_d.go_awake = 1'b0;
        s_d.wake_cnt = '0;
      end else begin
        s_d.wake_cnt = s_q.wake_cnt + 32'h1;
      end
    end
    // restore sequencer: wait for the port to end k
    unique case (s_q.rst_st)
      URA_IDLE: begin
        if (s_q.restore_bus) begin
          s_d.rst_st = URA_WAIT_END;
        end
      end
      URA_WAIT_END: begin
        if (!s_q.restore_bus) begin
          s_d.rst_st = URA_IDLE; // restore request dropped; no firmware write clears it
        end else if (!line_k) begin
          s_d.xcvr_speed_sel = XCVR_FS;
          s_d.termination_sel = s_q.saved_speed ? TERM_HS : TERM_FS;
          s_d.restore_bus = 1'b0;
          s_d.restore_done = 1'b1;
          s_d.shift_cnt = '0;
          s_d.rst_st = s_q.saved_speed ? URA_HS_SHIFT : URA_IDLE;
        end
      end
      URA_HS_SHIFT: begin
        // shift to hs before two ls bit times pass
        if (s_q.shift_cnt >= 16'(SHIFT_CYCLES - 1)) begin
          s_d.xcvr_speed_sel = XCVR_HS;
          s_d.rst_st = URA_IDLE;
        end else begin
          s_d.shift_cnt = s_q.shift_cnt + 16'h1;
        end
      end
      // the fourth code of the state field is unused; fall back to idle
      default: begin
        s_d.rst_st = URA_IDLE;
      end
    endcase
    // register writes; hardware set wins over write-one clear
    if (wr) begin
      unique case (PADDR_I)
        URA_CTRL_ADDR: begin
          if (w[CTRL_GO_AWAKE] && asleep) begin
            s_d.go_awake = 1'b1;
          end
          if (w[CTRL_RESTORE] && s_q.rst_st == URA_IDLE) begin
            s_d.restore_bus = 1'b1;
          end
          s_d.bus_active = w[CTRL_BUS_ACTIVE];
          s_d.bus_detect_disable = w[CTRL_DETECT_DIS];
          if (w[CTRL_SUSPEND] && !s_q.suspended) begin
            s_d.saved_speed = (s_q.xcvr_speed_sel == XCVR_HS);
            s_d.power_state = PWR_SLEEP;
          end
          s_d.suspended = w[CTRL_SUSPEND];
        end
        URA_STAT_ADDR: begin
          if (w[STAT_NON_IDLE] && !(asleep && line_k)) begin
            s_d.non_idle_seen = 1'b0;
          end
          if (w[STAT_DONE] && !(s_q.rst_st == URA_WAIT_END && !line_k)) begin
            s_d.restore_done = 1'b0;
          end
        end
        URA_XCVR_ADDR: begin
          s_d.xcvr_speed_sel = w[XCVR_SPEED];
          s_d.termination_sel = w[XCVR_TERM];
          s_d.operating_mode = w[XCVR_MODE_LO +: 2];
        end
        URA_IEN_ADDR: begin
          s_d.irq_en = w[IEN_TOP:IEN_NON_IDLE];
        end
        default: begin
        end
      endcase
    end
    // read data captured in setup, stable through access
    if (rd) begin
      s_d.rdata = '0;
      unique case (PADDR_I)
        URA_CTRL_ADDR: s_d.rdata = 32'({s_q.suspended, s_q.bus_detect_disable,
                                       s_q.bus_active, s_q.restore_bus, s_q.go_awake});
        URA_STAT_ADDR: s_d.rdata = 32'({LINE_LEVEL_I, s_q.power_state, s_q.saved_speed,
                                       BUS_SUPPLY_I, s_q.restore_done, s_q.non_idle_seen});
        URA_XCVR_ADDR: s_d.rdata = 32'({s_q.operating_mode, s_q.termination_sel,
                                       s_q.xcvr_speed_sel});
        URA_IEN_ADDR: s_d.rdata = 32'(s_q.irq_en);
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_q <= '0;
    end else if (!rst_n) begin
      s_q <= '0;
      s_q.rst_sync <= s_d.rst_sync;
      s_q.power_state <= PWR_ACTIVE; // powered and clocked after reset
      s_q.xcvr_speed_sel <= XCVR_FS; // detached defaults
      s_q.termination_sel <= TERM_HS;
      s_q.operating_mode <= MODE_NODRIVE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign PRDATA_O = s_q.rdata;
  assign PREADY_O = 1'b1; // zero wait states
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
  // combinational so it falls in the cycle the flag sets
  assign IRQ_OUT_N_O = ~irq_any(s_q.irq_en, s_q.non_idle_seen, s_q.restore_done);
  assign CLK_RUN_O = (s_q.power_state == PWR_ACTIVE);
  assign XCVR_SPEED_SEL_O = s_q.xcvr_speed_sel;
  assign TERMINATION_SEL_O = s_q.termination_sel;
  assign OPERATING_MODE_O = s_q.operating_mode;
  assign BUS_ACTIVE_O = s_q.bus_active;
  assign BUS_DETECT_DISABLE_O = s_q.bus_detect_disable;

  // ****************************************************
  // assertions
  // ****************************************************
  non_idle_set_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (s_q.power_state == PWR_SLEEP && LINE_LEVEL_I == LINE_K) |=> s_q.non_idle_seen)
    else $error("k while asleep did not set non-idle");
  irq_gate_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (s_q.non_idle_seen && s_q.irq_en[IEN_TOP] && s_q.irq_en[IEN_GROUP] &&
     s_q.irq_en[IEN_NON_IDLE]) |-> !IRQ_OUT_N_O)
    else $error("enabled non-idle did not assert irq");
  wake_time_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (s_q.go_awake && s_q.wake_cnt < 32'(WAKE_CYCLES - 1)) |=> !CLK_RUN_O)
    else $error("clock ran before wake delay");
  restore_end_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (s_q.rst_st == URA_WAIT_END && s_q.restore_bus && LINE_LEVEL_I != LINE_K)
    |=> (!s_q.restore_bus && s_q.restore_done))
    else $error("end of k did not complete restore");
  hs_shift_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    $rose(s_q.rst_st == URA_HS_SHIFT) |-> ##[1:53] (s_q.xcvr_speed_sel == XCVR_HS))
    else $error("high speed not restored in time");
  done_irq_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (s_q.restore_done && s_q.irq_en[IEN_TOP] && s_q.irq_en[IEN_GROUP] &&
     s_q.irq_en[IEN_DONE]) |-> !IRQ_OUT_N_O)
    else $error("enabled restore-done did not assert irq");
  flag_sticky_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (s_q.restore_done && !(wr && PADDR_I == URA_STAT_ADDR)) |=> s_q.restore_done)
    else $error("restore-done dropped without clear");
  irq_quiet_a: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (s_q.irq_en[IEN_TOP] == 1'b0) |-> IRQ_OUT_N_O)
    else $error("irq asserted with top enable off");

endmodule
`default_nettype wire

// ---- verilog/ura_pkg.sv ----
/*
 * constants, register map and state types of the usb resume and attach sequencer.
 * assumes a 40 MHz system clock and an apb master with 32-bit data.
 */
// Overview of operation
// - k while asleep at j sets non-idle flag
// - non-idle flag raises gated interrupt output
// - go-awake command, power active after startup delay
// - end of k restores mode, sets done
// - high speed resumes within two ls bits
// - restore-done flag raises gated interrupt output
// - bus supply high sets supply-present bit
// - port resets after 100 ms, firmware disables detect
// - suspend records current speed mode
package ura_pkg;

  // ****************************************************
  // register byte addresses
  // ****************************************************
  localparam logic [11:0] URA_CTRL_ADDR = 12'h000; // control bits
  localparam logic [11:0] URA_STAT_ADDR = 12'h004; // status, write one to clear flags
  localparam logic [11:0] URA_XCVR_ADDR = 12'h008; // transceiver settings
  localparam logic [11:0] URA_IEN_ADDR = 12'h00C; // interrupt enables

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int CTRL_GO_AWAKE = 0;
  localparam int CTRL_RESTORE = 1;
  localparam int CTRL_BUS_ACTIVE = 2;
  localparam int CTRL_DETECT_DIS = 3;
  localparam int CTRL_SUSPEND = 4;
  localparam int STAT_NON_IDLE = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_SUPPLY = 2;
  localparam int STAT_SAVED_HS = 3;
  localparam int STAT_PWR_LO = 4;
  localparam int STAT_LINE_LO = 6;
  localparam int XCVR_SPEED = 0;
  localparam int XCVR_TERM = 1;
  localparam int XCVR_MODE_LO = 2;
  localparam int IEN_NON_IDLE = 0;
  localparam int IEN_DONE = 1;
  localparam int IEN_GROUP = 2;
  localparam int IEN_TOP = 3;

  // ****************************************************
  // encodings and reset values
  // ****************************************************
  localparam logic [1:0] LINE_J = 2'h1; // full-speed idle
  localparam logic [1:0] LINE_K = 2'h2;
  localparam logic [1:0] PWR_SLEEP = 2'h0;
  localparam logic [1:0] PWR_ACTIVE = 2'h3;
  localparam logic XCVR_FS = 1'h1; // speed select 1 picks full speed
  localparam logic XCVR_HS = 1'h0;
  localparam logic TERM_FS = 1'h1;
  localparam logic TERM_HS = 1'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_NODRIVE = 2'h1;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_MHZ = 40;
  localparam int LS_TWO_BITS_NS = 1333; // two low-speed bit times
  localparam int HS_SHIFT_CYC = (LS_TWO_BITS_NS * CLK_MHZ) / 1000; // longest, round down
  localparam int WAKE_US = 2000; // oscillator plus pll start, plain default
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    URA_IDLE,
    URA_WAIT_END,
    URA_HS_SHIFT
  } ura_rst_t;

endpackage

// ---- test/ura_host_model.sv ----
/*
 * behavioural downstream port: drives the line state and the bus supply.
 * assumes start_i is a one-cycle pulse made by the bench on CLK_I.
 */
`timescale 1ns/100ps
`default_nettype none
module ura_host_model
  import ura_pkg::*;
#(
  parameter int K_CYCLES = 200 // stands in for the 20 ms resume drive
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic attach_i,
  output logic [1:0] line_o,
  output logic supply_o
);
  int cnt = 0; // cycles left in the resume drive, plus a short eop
  // ****************************************************
  // resume drive: k, then two se0 bits, then idle j
  // ****************************************************
  always @(posedge clk_i) begin
    if (start_i) begin
      cnt <= K_CYCLES + 2;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // the port stops k on its own after the fixed time, never earlier
  assign line_o = (cnt > 2) ? LINE_K : (cnt > 0) ? 2'h0 : LINE_J;
  assign supply_o = attach_i; // cable present means supply present
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
/*
 * self-checking bench for the resume and attach sequencer.
 * assumes the host model file is compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ura_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, start = 0, attach = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, irq_n, clk_run, spd, term, bact, ddis, supply;
  logic [1:0] mode, line;
  int n_fail = 0, checks_done = 0, n;
  ura_top #(.WAKE_CYCLES(8), .SHIFT_CYCLES(4)) i_ura_top (.CLK_I(clk), .RESETN_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LINE_LEVEL_I(line), .BUS_SUPPLY_I(supply), .IRQ_OUT_N_O(irq_n), .CLK_RUN_O(clk_run),
    .XCVR_SPEED_SEL_O(spd), .TERMINATION_SEL_O(term), .OPERATING_MODE_O(mode),
    .BUS_ACTIVE_O(bact), .BUS_DETECT_DISABLE_O(ddis));
  ura_host_model #(.K_CYCLES(200)) i_ura_host_model (.clk_i(clk), .start_i(start),
    .attach_i(attach), .line_o(line), .supply_o(supply));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ****************************************************
  // apb master and comparison helpers
  // ****************************************************
  // entered just after a rising edge; leaves one edge after release
  // waits for pready with no limit of its own; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // bounded wait for the speed select to reach a level, returns cycles taken
  task automatic wait_spd(input logic v, input int lim);
    n = 0;
    while (spd !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  // bounded wait for the internal clock to run, returns cycles taken
  task automatic wait_run(input int lim);
    n = 0;
    while (clk_run !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    apb(1'b0, URA_XCVR_ADDR, 32'h0);
    chk(rd, 32'h5, "detached xcvr defaults");
    chk({31'h0, irq_n}, 32'h1, "irq idle");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");
  endtask
  task automatic t_attach;
    apb(1'b1, URA_CTRL_ADDR, 32'h10); // asleep before the cable appears
    apb(1'b0, URA_STAT_ADDR, 32'h0);
    chk(rd[STAT_SUPPLY], 1'b0, "no supply while detached");
    attach <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, URA_STAT_ADDR, 32'h0);
    chk(rd[STAT_SUPPLY], 1'b1, "supply bit");
    chk(rd[5:4], PWR_SLEEP, "asleep at attach");
    apb(1'b1, URA_CTRL_ADDR, 32'h1);
    wait_run(40);
    chk({31'h0, clk_run}, 32'h1, "awake before attach steps");
    apb(1'b1, URA_XCVR_ADDR, 32'h3);
    apb(1'b1, URA_CTRL_ADDR, 32'h4);
    chk({bact, term, spd, mode}, 5'h1C, "fs attach outputs");
    apb(1'b1, URA_CTRL_ADDR, 32'hC);
    chk({31'h0, ddis}, 32'h1, "detect disable");
    $display("test attach done");
  endtask
  task automatic t_resume;
    apb(1'b1, URA_XCVR_ADDR, 32'h0); // high speed in use before suspend
    apb(1'b1, URA_IEN_ADDR, 32'hF);
    apb(1'b1, URA_CTRL_ADDR, 32'h1C);
    apb(1'b0, URA_STAT_ADDR, 32'h0);
    chk(rd[5:3], 3'h1, "saved hs, asleep");
    chk({31'h0, clk_run}, 32'h0, "clock stopped");
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, URA_STAT_ADDR, 32'h0);
    chk(rd[STAT_NON_IDLE], 1'b1, "non-idle seen");
    chk({31'h0, irq_n}, 32'h0, "non-idle irq");
    apb(1'b1, URA_CTRL_ADDR, 32'hD);
    wait_run(40);
    chk({31'h0, clk_run}, 32'h1, "clock running");
    chk(n >= 5, 1'b1, "wake not early");
    chk({31'h0, irq_n}, 32'h0, "irq held while flag set");
    apb(1'b1, URA_STAT_ADDR, 32'h1);
    chk({31'h0, irq_n}, 32'h1, "irq cleared");
    apb(1'b0, URA_STAT_ADDR, 32'h0);
    chk(rd[7:4], {LINE_K, PWR_ACTIVE}, "active and still k");
    apb(1'b1, URA_CTRL_ADDR, 32'hE);
    wait_spd(1'b1, 260);
    @(negedge clk);
    chk({term, spd, irq_n}, 3'h2, "restored fs step, done irq");
    wait_spd(1'b0, 8);
    chk(n <= 5, 1'b1, "hs shift in time");
    chk({31'h0, spd}, 32'h0, "hs restored");
    @(posedge clk);
    apb(1'b0, URA_CTRL_ADDR, 32'h0);
    chk(rd[CTRL_RESTORE], 1'b0, "restore bit cleared");
    apb(1'b0, URA_STAT_ADDR, 32'h0);
    chk(rd[STAT_DONE], 1'b1, "restore done flag");
    $display("test resume done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************************
  // main sequence and watchdog
  // ****************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_attach();
    t_resume();
    finish_test();
  end
  // the whole run needs well under two thousand cycles
  initial begin
    #(25 * 20000);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
